// file: core/upc_consts.svh
// Register offsets, field positions, reset values and limits of the endpoint packet configuration block
`ifndef UPC_CONSTS_SVH
`define UPC_CONSTS_SVH

`define UPC_OFS_INDEX 12'h000
`define UPC_OFS_CFG0 12'h004
`define UPC_OFS_RPC 12'h008
`define UPC_OFS_DBUF 12'h00C
`define UPC_OFS_MODE 12'h010
`define UPC_OFS_CTRL 12'h014
`define UPC_OFS_STAT 12'h018

`define UPC_PAYLOAD_MULTIPLIER_MSB 15
`define UPC_PAYLOAD_MULTIPLIER_LSB 11
`define UPC_MAX_PACKET_SIZE_MSB 10
`define UPC_MAX_PACKET_SIZE_LSB 0
`define UPC_RPC_MSB 15
`define UPC_DBUF_TX_MSB 23
`define UPC_DBUF_TX_LSB 17
`define UPC_DBUF_RX_MSB 7
`define UPC_DBUF_RX_LSB 1
`define UPC_MODE_TYPE_MSB 1
`define UPC_MODE_TYPE_LSB 0
`define UPC_MODE_AUTO 2
`define UPC_MODE_SPLIT 3
`define UPC_CTRL_HOST 0
`define UPC_CTRL_HS 1
`define UPC_STAT_RESTART 0
`define UPC_STAT_DONE 16
`define UPC_STAT_PAYLOAD_MULTIPLIER_BAD 17
`define UPC_STAT_ODD 18

`define UPC_RST_INDEX 3'h0
`define UPC_RST_CFG 16'h0000
`define UPC_RST_RPC 16'h0000
`define UPC_RST_DBUF 7'h00
`define UPC_RST_OUT16 16'h0000
`define UPC_RST_TRANS 6'h01

`define UPC_HS_PAYLOAD_MULTIPLIER_LO 5'h02
`define UPC_HS_PAYLOAD_MULTIPLIER_HI 5'h03

`endif

// file: core/upc_pkg.sv
// Types shared by the endpoint packet configuration block
package upc_pkg;

    typedef enum logic [1:0] {
        UPC_XFER_CTRL = 2'h0,
        UPC_XFER_ISO = 2'h1,
        UPC_XFER_BULK = 2'h2,
        UPC_XFER_INT = 2'h3
    } upc_xfer_t;

    typedef enum logic [1:0] {
        UPC_ST_IDLE = 2'b01,
        UPC_ST_WAIT = 2'b10
    } upc_state_t;

endpackage

// file: core/upc_cfg_mem.sv
// Per-endpoint payload configuration store with two registered read ports
`timescale 1ns/1ps
`include "upc_consts.svh"
module upc_cfg_mem (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic we,
    input wire logic [2:0] waddr,
    input wire logic [15:0] wdata,
    input wire logic [2:0] raddr_a,
    output logic [15:0] rdata_a,
    input wire logic [2:0] raddr_b,
    output logic [15:0] rdata_b
);

    logic [15:0] mem [0:7];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                mem[i] <= `UPC_RST_CFG;
            end
        end else if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_a <= `UPC_RST_CFG;
            rdata_b <= `UPC_RST_CFG;
        end else begin
            rdata_a <= mem[raddr_a];
            rdata_b <= mem[raddr_b];
        end
    end

endmodule // upc_cfg_mem

// file: core/upc_payload_calc.sv
// Payload size and transaction count derived from one endpoint's configuration word
`timescale 1ns/1ps
`include "upc_consts.svh"
module upc_payload_calc import upc_pkg::*; (
    input wire logic [15:0] cfg_word,
    input wire upc_xfer_t xfer,
    input wire logic split,
    input wire logic high_speed,
    output logic [15:0] payload,
    output logic [5:0] max_trans,
    output logic payload_multiplier_bad,
    output logic odd_max_packet_size
);

    wire [10:0] tx_max_payload = cfg_word[`UPC_MAX_PACKET_SIZE_MSB:`UPC_MAX_PACKET_SIZE_LSB];
    wire [4:0] payload_multiplier = cfg_word[`UPC_PAYLOAD_MULTIPLIER_MSB:`UPC_PAYLOAD_MULTIPLIER_LSB];
    wire [5:0] payload_multiplier_p1 = {1'b0, payload_multiplier} + 6'h01;
    wire periodic = (xfer == UPC_XFER_ISO) || (xfer == UPC_XFER_INT);
    wire bulk_split = (xfer == UPC_XFER_BULK) && split;
    wire scaled = periodic || bulk_split;
    wire hs_periodic = periodic && high_speed;
    wire [16:0] product = {6'h00, tx_max_payload} * {11'h000, payload_multiplier_p1};

    // Largest product is 2047 * 32, which still fits 16 bits
    assign payload = scaled ? product[15:0] : {5'h00, tx_max_payload};
    assign payload_multiplier_bad = hs_periodic && (payload_multiplier != `UPC_HS_PAYLOAD_MULTIPLIER_LO)
        && (payload_multiplier != `UPC_HS_PAYLOAD_MULTIPLIER_HI);
    assign odd_max_packet_size = tx_max_payload[0];

    // Illegal high-speed multipliers fall back to one transaction per microframe
    assign max_trans = hs_periodic ? (payload_multiplier_bad ? 6'h01 : {1'b0, payload_multiplier})
        : (bulk_split ? payload_multiplier_p1 : 6'h01);

endmodule // upc_payload_calc

// file: core/upc_top.sv
// APB register block and link-side logic for endpoint packet sizing, request counting and double buffering
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "upc_consts.svh"

module upc_top import upc_pkg::*; (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [2:0] LINK_EP,
    output logic [15:0] PAYLOAD_BYTES,
    output logic [5:0] MAX_TRANSACTIONS,
    output logic LINK_PAYLOAD_MULTIPLIER_BAD,
    output logic [6:0] TX_DBUF_OFF,
    output logic [6:0] RX_DBUF_OFF,
    output logic HOST_MODE,
    input wire logic IN_SENT,
    input wire logic [2:0] IN_EP,
    output logic [6:0] REQ_ALLOW
);

    function automatic logic [31:0] strb_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Register state
    upc_state_t state;
    upc_state_t next_state;
    logic [2:0] ep_index;
    logic host_mode;
    logic high_speed;
    logic [6:0] tx_dbuf;
    logic [6:0] rx_dbuf;
    logic [15:0] rpc [0:7];
    logic [15:0] issued [0:7];
    logic [15:0] next_issued [0:7];
    upc_xfer_t xtype [0:7];
    logic [7:0] automatic_request_option;
    logic [7:0] split;
    logic [7:0] limit_on;
    logic [7:0] allow;
    logic [7:0] inc;
    logic [7:0] restart;
    logic [7:0] done;
    logic [2:0] link_ep_q;

    // Memory and calculator wires
    logic [15:0] cfg_rd_a;
    logic [15:0] cfg_rd_b;
    logic [15:0] idx_payload;
    logic [5:0] idx_trans;
    logic idx_payload_multiplier_bad;
    logic idx_odd;
    logic [15:0] link_payload;
    logic [5:0] link_trans;
    logic link_payload_multiplier_bad;

    // Bus decode
    wire access = PSEL && PENABLE;
    wire setup = PSEL && !PENABLE;
    wire sel_index = (PADDR == `UPC_OFS_INDEX);
    wire sel_cfg = (PADDR == `UPC_OFS_CFG0);
    wire sel_rpc = (PADDR == `UPC_OFS_RPC);
    wire sel_dbuf = (PADDR == `UPC_OFS_DBUF);
    wire sel_mode = (PADDR == `UPC_OFS_MODE);
    wire sel_ctrl = (PADDR == `UPC_OFS_CTRL);
    wire sel_stat = (PADDR == `UPC_OFS_STAT);
    wire mapped = sel_index || sel_cfg || sel_rpc || sel_dbuf || sel_mode || sel_ctrl || sel_stat;
    wire idx_ok = (ep_index != 3'h0);
    wire cfg_read = access && !PWRITE && sel_cfg;
    wire wr_ok = access && PWRITE && PREADY && mapped;

    // Configuration reads wait one cycle for the memory's registered port
    assign PREADY = !(cfg_read && (state == UPC_ST_IDLE));
    assign PSLVERR = access && !mapped;

    wire wr_index = wr_ok && sel_index;
    wire wr_cfg = wr_ok && sel_cfg && idx_ok;
    wire wr_rpc = wr_ok && sel_rpc && idx_ok;
    wire wr_dbuf = wr_ok && sel_dbuf;
    wire wr_mode = wr_ok && sel_mode && idx_ok;
    wire wr_ctrl = wr_ok && sel_ctrl;
    wire wr_stat = wr_ok && sel_stat && idx_ok;

    // Current values of the addressed register, used for byte-lane merging
    wire [31:0] cur_index = {29'h0, ep_index};
    wire [31:0] cur_cfg = idx_ok ? {16'h0000, cfg_rd_a} : 32'h0000_0000;
    wire [31:0] cur_rpc = {16'h0000, rpc[ep_index]};
    wire [31:0] cur_dbuf = {8'h00, tx_dbuf, 1'b0, 8'h00, rx_dbuf, 1'b0};
    wire [31:0] cur_mode = {28'h0, split[ep_index], automatic_request_option[ep_index], xtype[ep_index]};
    wire [31:0] cur_ctrl = {30'h0, high_speed, host_mode};
    wire [31:0] cur_stat = {13'h0, idx_odd, idx_payload_multiplier_bad, done[ep_index], issued[ep_index]};

    wire [31:0] m_index = strb_merge(cur_index, PWDATA, PSTRB);
    wire [31:0] m_cfg = strb_merge(cur_cfg, PWDATA, PSTRB);
    wire [31:0] m_rpc = strb_merge(cur_rpc, PWDATA, PSTRB);
    wire [31:0] m_dbuf = strb_merge(cur_dbuf, PWDATA, PSTRB);
    wire [31:0] m_mode = strb_merge(cur_mode, PWDATA, PSTRB);
    wire [31:0] m_ctrl = strb_merge(cur_ctrl, PWDATA, PSTRB);
    wire stat_restart = wr_stat && PSTRB[0] && PWDATA[`UPC_STAT_RESTART];

    wire [31:0] rd_sel =
        sel_index ? cur_index :
        sel_cfg ? cur_cfg :
        sel_rpc ? cur_rpc :
        sel_dbuf ? cur_dbuf :
        sel_mode ? cur_mode :
        sel_ctrl ? cur_ctrl :
        sel_stat ? cur_stat : 32'h0000_0000;

    always_comb begin
        next_state = state;
        unique case (state)
            UPC_ST_IDLE: begin
                if (cfg_read) begin
                    next_state = UPC_ST_WAIT;
                end
            end
            UPC_ST_WAIT: begin
                next_state = UPC_ST_IDLE;
            end
            default: begin
                next_state = UPC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            state <= UPC_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Read data is captured while the transfer is held, so it is stable when sampled
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            PRDATA <= 32'h0000_0000;
        end else if (setup || (access && !PREADY)) begin
            PRDATA <= PWRITE ? 32'h0000_0000 : rd_sel;
        end
    end

    // Global registers
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ep_index <= `UPC_RST_INDEX;
            host_mode <= 1'b0;
            high_speed <= 1'b0;
        end else begin
            if (wr_index) begin
                ep_index <= m_index[2:0];
            end
            if (wr_ctrl) begin
                host_mode <= m_ctrl[`UPC_CTRL_HOST];
                high_speed <= m_ctrl[`UPC_CTRL_HS];
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            tx_dbuf <= `UPC_RST_DBUF;
            rx_dbuf <= `UPC_RST_DBUF;
        end else if (wr_dbuf) begin
            tx_dbuf <= m_dbuf[`UPC_DBUF_TX_MSB:`UPC_DBUF_TX_LSB];
            rx_dbuf <= m_dbuf[`UPC_DBUF_RX_MSB:`UPC_DBUF_RX_LSB];
        end
    end

    assign TX_DBUF_OFF = tx_dbuf;
    assign RX_DBUF_OFF = rx_dbuf;
    assign HOST_MODE = host_mode;

    // Per-endpoint request counting; slot 0 is never written and stays at reset
    for (genvar g = 0; g < 8; g++) begin : g_ep
        wire hit = (ep_index == 3'(g));
        wire in_hit = IN_SENT && (IN_EP == 3'(g)) && (g != 0);

        assign limit_on[g] = host_mode && automatic_request_option[g];
        assign allow[g] = !limit_on[g] || (rpc[g] == 16'h0000) || (issued[g] < rpc[g]);
        assign done[g] = limit_on[g] && (rpc[g] != 16'h0000) && (issued[g] >= rpc[g]);
        assign inc[g] = in_hit && limit_on[g] && allow[g];
        assign restart[g] = (wr_rpc || stat_restart) && hit;

        // A request landing on the restart cycle is counted into the new block
        assign next_issued[g] = restart[g] ? {15'h0000, inc[g]} : issued[g] + {15'h0000, inc[g]};

        always_ff @(posedge CLOCK or negedge RESET_N) begin
            if (!RESET_N) begin
                rpc[g] <= `UPC_RST_RPC;
                issued[g] <= `UPC_RST_OUT16;
            end else begin
                issued[g] <= next_issued[g];
                if (wr_rpc && hit) begin
                    rpc[g] <= m_rpc[`UPC_RPC_MSB:0];
                end
            end
        end

        always_ff @(posedge CLOCK or negedge RESET_N) begin
            if (!RESET_N) begin
                xtype[g] <= UPC_XFER_CTRL;
                automatic_request_option[g] <= 1'b0;
                split[g] <= 1'b0;
            end else if (wr_mode && hit) begin
                xtype[g] <= upc_xfer_t'(m_mode[`UPC_MODE_TYPE_MSB:`UPC_MODE_TYPE_LSB]);
                automatic_request_option[g] <= m_mode[`UPC_MODE_AUTO];
                split[g] <= m_mode[`UPC_MODE_SPLIT];
            end
        end
    end

    assign REQ_ALLOW = allow[7:1];

    upc_cfg_mem u_mem (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .we(wr_cfg),
        .waddr(ep_index),
        .wdata(m_cfg[15:0]),
        .raddr_a(ep_index),
        .rdata_a(cfg_rd_a),
        .raddr_b(LINK_EP),
        .rdata_b(cfg_rd_b)
    );

    upc_payload_calc u_calc_idx (
        .cfg_word(cfg_rd_a),
        .xfer(xtype[ep_index]),
        .split(split[ep_index]),
        .high_speed(high_speed),
        .payload(idx_payload),
        .max_trans(idx_trans),
        .payload_multiplier_bad(idx_payload_multiplier_bad),
        .odd_max_packet_size(idx_odd)
    );

    upc_payload_calc u_calc_link (
        .cfg_word(cfg_rd_b),
        .xfer(xtype[link_ep_q]),
        .split(split[link_ep_q]),
        .high_speed(high_speed),
        .payload(link_payload),
        .max_trans(link_trans),
        .payload_multiplier_bad(link_payload_multiplier_bad),
        .odd_max_packet_size()
    );

    // Link answers two cycles after the endpoint number is presented
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            link_ep_q <= 3'h0;
            PAYLOAD_BYTES <= `UPC_RST_OUT16;
            MAX_TRANSACTIONS <= `UPC_RST_TRANS;
            LINK_PAYLOAD_MULTIPLIER_BAD <= 1'b0;
        end else begin
            link_ep_q <= LINK_EP;
            PAYLOAD_BYTES <= link_payload;
            MAX_TRANSACTIONS <= link_trans;
            LINK_PAYLOAD_MULTIPLIER_BAD <= link_payload_multiplier_bad;
        end
    end

endmodule // upc_top

// file: sim/upc_top_properties.sv
// Concurrent checks on the ports of the endpoint packet configuration block
`timescale 1ns/1ps
module upc_top_properties (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [5:0] MAX_TRANSACTIONS,
    input wire logic LINK_PAYLOAD_MULTIPLIER_BAD,
    input wire logic [6:0] TX_DBUF_OFF,
    input wire logic [6:0] RX_DBUF_OFF,
    input wire logic HOST_MODE,
    input wire logic [6:0] REQ_ALLOW
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    wire logic rd_done = PSEL && PENABLE && PREADY && !PWRITE;
    wire logic wr_done = PSEL && PENABLE && PREADY && PWRITE;

    a_dbuf_gap_zero: assert property (rd_done && PADDR == 12'h00C |-> PRDATA[0] == 1'b0 && PRDATA[16] == 1'b0
        && PRDATA[31:24] == 8'h00 && PRDATA[15:8] == 8'h00) else $error("double buffer reserved bits set");
    a_count_upper_zero: assert property (rd_done && PADDR == 12'h008 |-> PRDATA[31:16] == 16'h0000)
        else $error("request count upper half set");
    a_dbuf_follows_write: assert property (wr_done && PADDR == 12'h00C && PSTRB == 4'hF |=>
        TX_DBUF_OFF == $past(PWDATA[23:17]))
        else $error("transmit disables not taken");
    a_rx_dbuf_write: assert property (wr_done && PADDR == 12'h00C && PSTRB == 4'hF |=>
        RX_DBUF_OFF == $past(PWDATA[7:1]))
        else $error("receive disables not taken");
    a_bad_payload_multiplier_single: assert property (LINK_PAYLOAD_MULTIPLIER_BAD |-> MAX_TRANSACTIONS == 6'h01)
        else $error("illegal multiplier gives more than one transaction");
    a_trans_range: assert property (MAX_TRANSACTIONS >= 6'h01 && MAX_TRANSACTIONS <= 6'h20)
        else $error("transaction count out of range");
    a_allow_no_host: assert property (!HOST_MODE && !$past(HOST_MODE) |-> REQ_ALLOW == 7'h7F)
        else $error("request limit active outside host mode");
    a_cfg_read_wait: assert property (PSEL && PENABLE && !PWRITE && PADDR == 12'h004 && !PREADY |=> PREADY)
        else $error("configuration read stalls too long");
    a_write_no_wait: assert property (PSEL && PENABLE && PWRITE |-> PREADY)
        else $error("write stalled");
    a_unmapped_error: assert property (PSEL && PENABLE && PADDR > 12'h018 |-> PSLVERR)
        else $error("unmapped access not refused");
endmodule // upc_top_properties

bind upc_top upc_top_properties upc_top_properties_i (.CLOCK(CLOCK), .RESET_N(RESET_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .MAX_TRANSACTIONS(MAX_TRANSACTIONS), .LINK_PAYLOAD_MULTIPLIER_BAD(LINK_PAYLOAD_MULTIPLIER_BAD),
    .TX_DBUF_OFF(TX_DBUF_OFF), .RX_DBUF_OFF(RX_DBUF_OFF), .HOST_MODE(HOST_MODE), .REQ_ALLOW(REQ_ALLOW));

// file: sim/upc_link_model.sv
// Link engine stand-in that issues IN requests while its endpoint is allowed
`timescale 1ns/1ps
module upc_link_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic slow,
    input wire logic [2:0] ep,
    input wire logic [6:0] allow,
    output logic in_sent,
    output logic [2:0] in_ep,
    output logic [15:0] sent
);
    logic gap;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_sent <= 1'b0;
            in_ep <= 3'h0;
            sent <= 16'h0000;
            gap <= 1'b0;
        end else begin
            gap <= slow & ~gap;
            in_sent <= go && !gap && allow[ep - 3'h1];
            // Endpoint lines toggle between requests so stale values are never trusted
            in_ep <= (go && !gap) ? ep : ~in_ep;
            if (in_sent && allow[in_ep - 3'h1]) begin
                sent <= sent + 16'h0001;
            end
        end
    end
endmodule // upc_link_model

// file: sim/test_usb_endpoint_packet_config.sv
// Register and link-side tests of the endpoint packet configuration block
`timescale 1ns/1ps
module test_usb_endpoint_packet_config;
    import upc_pkg::*;
    logic CLOCK = 1'b0, RESET_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, err, go = 1'b0, slow = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA;
    logic [3:0] PSTRB = 4'hF;
    logic PREADY, PSLVERR, LINK_PAYLOAD_MULTIPLIER_BAD, HOST_MODE, IN_SENT;
    logic [2:0] LINK_EP = 3'h3, IN_EP;
    logic [15:0] PAYLOAD_BYTES, sent;
    logic [5:0] MAX_TRANSACTIONS;
    logic [6:0] TX_DBUF_OFF, RX_DBUF_OFF, REQ_ALLOW;
    int fails = 0, checked = 0;

    upc_top upc_top_i (.CLOCK(CLOCK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .LINK_EP(LINK_EP), .PAYLOAD_BYTES(PAYLOAD_BYTES), .MAX_TRANSACTIONS(MAX_TRANSACTIONS),
        .LINK_PAYLOAD_MULTIPLIER_BAD(LINK_PAYLOAD_MULTIPLIER_BAD), .TX_DBUF_OFF(TX_DBUF_OFF), .RX_DBUF_OFF(RX_DBUF_OFF),
        .HOST_MODE(HOST_MODE), .IN_SENT(IN_SENT), .IN_EP(IN_EP), .REQ_ALLOW(REQ_ALLOW));
    upc_link_model upc_link_model_i (.clk(CLOCK), .rst_n(RESET_N), .go(go), .slow(slow), .ep(3'h5),
        .allow(REQ_ALLOW), .in_sent(IN_SENT), .in_ep(IN_EP), .sent(sent));

    initial begin
        forever #12.5 CLOCK = ~CLOCK;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        logic rdy;
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        n = 0;
        // Answer is sampled settled, mid-cycle, and the transfer ends at the following rising edge
        do begin
            @(negedge CLOCK);
            rdy = PREADY;
            q = PRDATA;
            err = PSLVERR;
            @(posedge CLOCK);
            n++;
        end while (rdy !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLOCK);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask

    task automatic cfg(input logic [1:0] ty, input logic sp, input logic hs, input logic [4:0] m,
                       input logic [10:0] mp, input logic [15:0] pay, input logic [5:0] tr, input logic bad);
        wr(12'h014, {30'h0, hs, 1'b0});
        wr(12'h010, {28'h0, sp, 1'b0, ty});
        wr(12'h004, {16'h0, m, mp});
        rd(12'h004, {16'h0, m, mp});
        repeat (4) @(posedge CLOCK);
        check(PAYLOAD_BYTES, pay);
        check(MAX_TRANSACTIONS, tr);
        check(LINK_PAYLOAD_MULTIPLIER_BAD, bad);
    endtask

    task automatic burst(input int cycles);
        go <= 1'b1;
        repeat (cycles) @(posedge CLOCK);
        go <= 1'b0;
        repeat (3) @(posedge CLOCK);
    endtask

    task automatic summarize;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge CLOCK);
        fails++;
        summarize();
    end

    initial begin
        repeat (2) @(posedge CLOCK);
        RESET_N <= 1'b1;
        @(posedge CLOCK);
        wr(12'h000, 32'h1);
        rd(12'h008, 32'h0);
        rd(12'h00C, 32'h0);
        wr(12'h00C, 32'hFFFFFFFF);
        rd(12'h00C, 32'h00FE00FE);
        check(TX_DBUF_OFF, 32'h7F);
        check(RX_DBUF_OFF, 32'h7F);
        wr(12'h00C, 32'h00A40052);
        rd(12'h00C, 32'h00A40052);
        check({TX_DBUF_OFF, RX_DBUF_OFF}, {7'h52, 7'h29});
        wr(12'h000, 32'h2);
        wr(12'h008, 32'hFFFFFFFF);
        rd(12'h008, 32'h0000FFFF);
        rd(12'h020, 32'h0);
        check(err, 1'b1);
        $display("registers done");
        wr(12'h000, 32'h3);
        cfg(UPC_XFER_ISO, 1'b0, 1'b0, 5'h02, 11'd100, 16'd300, 6'd1, 1'b0);
        cfg(UPC_XFER_ISO, 1'b0, 1'b1, 5'h02, 11'd100, 16'd300, 6'd2, 1'b0);
        cfg(UPC_XFER_INT, 1'b0, 1'b1, 5'h03, 11'd64, 16'd256, 6'd3, 1'b0);
        cfg(UPC_XFER_INT, 1'b0, 1'b1, 5'h01, 11'd64, 16'd128, 6'd1, 1'b1);
        cfg(UPC_XFER_BULK, 1'b1, 1'b0, 5'h1F, 11'd512, 16'd16384, 6'd32, 1'b0);
        cfg(UPC_XFER_BULK, 1'b0, 1'b1, 5'h03, 11'd512, 16'd512, 6'd1, 1'b0);
        cfg(UPC_XFER_ISO, 1'b0, 1'b0, 5'h00, 11'h7FE, 16'h07FE, 6'd1, 1'b0);
        $display("payload done");
        wr(12'h014, 32'h1);
        check(HOST_MODE, 1'b1);
        wr(12'h000, 32'h5);
        wr(12'h010, 32'h6);
        wr(12'h008, 32'h3);
        burst(12);
        check(REQ_ALLOW[4], 1'b0);
        check(sent, 16'd3);
        rd(12'h018, 32'h00010003);
        slow <= 1'b1;
        wr(12'h008, 32'h2);
        check(REQ_ALLOW[4], 1'b1);
        burst(12);
        check(sent, 16'd5);
        rd(12'h018, 32'h00010002);
        wr(12'h010, 32'h2);
        burst(10);
        check(REQ_ALLOW, 7'h7F);
        wr(12'h014, 32'h0);
        check(HOST_MODE, 1'b0);
        check(REQ_ALLOW, 7'h7F);
        $display("request count done");
        summarize();
    end
endmodule // test_usb_endpoint_packet_config
